// >>> include/pie_pkg.sv
// package of constants and types for the prioritized interrupt and event transfer block
`default_nettype none
package pie_pkg;
    localparam int NODES        = 16;
    localparam int CHANNELS     = 8;
    localparam int PRIO_W       = 4;
    localparam int ADDR_W       = 16;
    // response times in cpu clocks
    localparam int RESP_CACHED  = 7;
    localparam int RESP_PLAIN   = 11;
    // vector table
    localparam logic [15:0] VEC_STEP = 16'h0004;
    // register map: node control words 0x000 + 4*n
    localparam logic [11:0] OFS_NODE     = 12'h000;
    // channel pointers and counters 0x100 + 16*c
    localparam logic [11:0] OFS_CHAN     = 12'h100;
    localparam logic [11:0] OFS_EDGE     = 12'h200;
    localparam logic [11:0] OFS_TRAP     = 12'h204;
    localparam logic [11:0] OFS_STAT     = 12'h208;
    localparam logic [11:0] OFS_IRQ_ST   = 12'h20C;
    localparam logic [11:0] OFS_IRQ_MSK  = 12'h210;
    localparam logic [11:0] OFS_CFG      = 12'h214;
    // node control word fields
    localparam int F_REQ  = 7;
    localparam int F_EN   = 6;
    localparam int F_ETC  = 5;   // service by event transfer channel
    localparam int F_CHL  = 8;   // channel number bits 10:8
    localparam int F_PRIO = 0;   // priority bits 3:0
    // channel config bits in counter word
    localparam int C_INC_SRC = 16;
    localparam int C_INC_DST = 17;
    localparam int C_WORD    = 18;
    localparam int C_CONT    = 19;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // event status bits
    localparam int EV_VEC   = 0;
    localparam int EV_XFER  = 1;
    localparam int EV_ZERO  = 2;
    localparam int EV_TRAP  = 3;

    typedef struct packed {
        logic        req;
        logic        en;
        logic        etc;
        logic [2:0]  chan;
        logic [3:0]  prio;
    } pie_node_s;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] count;
        logic        inc_src;
        logic        inc_dst;
        logic        word;
        logic        cont;
    } pie_chan_s;

    typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_OFF} pie_edge_e;
endpackage
`default_nettype wire

// >>> sim/pie_bench.sv
// self-checking bench for the interrupt and event transfer block
`default_nettype none
module pie_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] preq = 16'h0;
    logic [3:0]  pins = 4'h0;
    logic        trap_v = 1'b0;
    logic [3:0]  trap_n = 4'h0;
    logic [7:0]  delay = 8'h00;
    logic [31:0] prdata;
    logic [15:0] vaddr, bsrc, bdst;
    logic [3:0]  level;
    logic        pready, pslverr, done, vreq, steal, bword, irq;
    int          errors = 0;
    int          tests_run = 0;
    pie_top i_dut (.CLK(clk), .RST_B(rst_b), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PERIPH_REQ(preq), .FAST_PIN(pins),
        .TRAP_VALID(trap_v), .TRAP_NUM(trap_n), .SERVICE_DONE(done),
        .CPU_VEC_REQ(vreq), .CPU_VEC_ADDR(vaddr), .CPU_LEVEL(level),
        .BUS_STEAL(steal), .BUS_SRC(bsrc), .BUS_DST(bdst), .BUS_WORD(bword),
        .IRQ(irq));
    pie_cpu_model i_cpu (.clk(clk), .rst_b(rst_b), .vec_req(vreq), .vec_addr(vaddr),
        .steal(steal), .src(bsrc), .dst(bdst), .word(bword), .delay(delay),
        .service_done(done));
    // free running 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end
    // compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waits for ready
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        check(r, x);
    endtask
    // node control word: channel, {req,en,transfer}, priority
    function automatic logic [31:0] nw(input logic [3:0] p, input logic [2:0] c,
                                       input logic [2:0] f);
        return {21'h0, c, f, 1'b0, p};
    endfunction
    // wait until k services ended and no vector is presented
    task automatic wait_n(input int k);
        int n;
        n = 0;
        while ((i_cpu.vec_q.size() < k || vreq !== 1'b0) && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check(n < 2000, 1'b1);
    endtask
    task automatic pulse(input logic [15:0] m);
        preq <= m;
        @(posedge clk);
        preq <= 16'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rdchk(12'h00C, pie_pkg::RESET_WORD);
        wr(12'h00C, nw(4'hF, 3'h5, 3'h2));
        rdchk(12'h00C, 32'h0000_054F);
        wr(12'h00C, 32'h0);
        apb(12'h300, 1'b0, 32'h0, r, e);
        check(r, 32'h0);
        check(e, 1'b1);
        $display("t_regs done");
    endtask
    // software request on an unassigned node, timed from the write edge
    task automatic t_resp(input logic cache, input int resp);
        int n;
        i_cpu.vec_q.delete();
        wr(pie_pkg::OFS_CFG, {31'h0, cache});
        wr(12'h008, nw(4'h3, 3'h0, 3'h6));
        n = 0;
        while (vreq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check(n >= resp && n <= resp + 4, 1'b1);
        check(vaddr, 16'h0008);
        check(level, 4'h3);
        wait_n(1);
        wr(12'h008, 32'h0);
        $display("t_resp done");
    endtask
    // slow cpu: equal levels wait, ties go to the lower node, disabled stays
    task automatic t_prio();
        i_cpu.vec_q.delete();
        delay <= 8'd20;
        wr(12'h014, nw(4'h2, 3'h0, 3'h2));
        wr(12'h024, nw(4'h7, 3'h0, 3'h2));
        wr(12'h028, nw(4'h7, 3'h0, 3'h2));
        wr(12'h030, nw(4'hF, 3'h0, 3'h0));
        pulse(16'h1620);
        wait_n(3);
        check(i_cpu.vec_q[0], 16'h0024);
        check(i_cpu.vec_q[1], 16'h0028);
        check(i_cpu.vec_q[2], 16'h0014);
        rdchk(12'h030, 32'h0000_008F);
        wr(12'h030, 32'h0);
        delay <= 8'd0;
        $display("t_prio done");
    endtask
    // counted word channel ending in a vector, then a continuous byte channel
    task automatic t_xfer();
        i_cpu.vec_q.delete();
        i_cpu.steal_q.delete();
        wr(12'h130, 32'h2000_1000);
        wr(12'h134, 32'h0007_0002);
        wr(12'h018, nw(4'h4, 3'h3, 3'h3));
        pulse(16'h0040);
        pulse(16'h0040);
        wait_n(1);
        check(i_cpu.steal_q[0], 40'h01_2000_1000);
        check(i_cpu.steal_q[1], 40'h01_2002_1002);
        check(i_cpu.steal_q.size(), 2);
        check(i_cpu.vec_q[0], 16'h0018);
        rdchk(12'h134, 32'h0007_0000);
        wr(12'h110, 32'h0080_0040);
        wr(12'h114, 32'h0009_0005);
        wr(12'h01C, nw(4'h4, 3'h1, 3'h3));
        pulse(16'h0080);
        pulse(16'h0080);
        check(i_cpu.steal_q[2], 40'h00_0080_0040);
        check(i_cpu.steal_q[3], 40'h00_0080_0041);
        rdchk(12'h114, 32'h0009_0005);
        rdchk(12'h130, 32'h2004_1004);
        wr(12'h01C, 32'h0);
        $display("t_xfer done");
    endtask
    // fast pins: 0 rising, 1 falling, 2 both, 3 off; nodes left disabled
    task automatic edge_pass(input logic [3:0] lvl, input logic [3:0] x);
        pins <= lvl;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rdchk(12'(4 * i), {24'h0, x[i], 7'h0});
            wr(12'(4 * i), 32'h0);
        end
    endtask
    task automatic t_edge();
        wr(pie_pkg::OFS_EDGE, 32'h0000_00E4);
        edge_pass(4'hF, 4'h5);
        edge_pass(4'h0, 4'h6);
        $display("t_edge done");
    endtask
    // trap into node 11, interrupt raised by the unmasked trap event only
    task automatic t_trap();
        i_cpu.vec_q.delete();
        wr(pie_pkg::OFS_IRQ_MSK, 32'h8);
        wr(12'h02C, nw(4'h1, 3'h0, 3'h2));
        trap_v <= 1'b1;
        trap_n <= 4'hB;
        @(posedge clk);
        trap_v <= 1'b0;
        wait_n(1);
        check(i_cpu.vec_q[0], 16'h002C);
        check(irq, 1'b1);
        wr(pie_pkg::OFS_IRQ_ST, 32'h8);
        @(posedge clk);
        check(irq, 1'b0);
        rdchk(pie_pkg::OFS_IRQ_ST, 32'h7);
        wr(pie_pkg::OFS_IRQ_ST, 32'hF);
        rdchk(pie_pkg::OFS_IRQ_ST, 32'h0);
        $display("t_trap done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_resp(1'b1, pie_pkg::RESP_CACHED);
        t_resp(1'b0, pie_pkg::RESP_PLAIN);
        t_prio();
        t_xfer();
        t_edge();
        t_trap();
        tally_and_finish();
    end
    // hang guard, well beyond the expected run
    initial begin
        #3000000;
        errors++;
        tally_and_finish();
    end
endmodule
bind pie_top pie_chk #(.NODES(NODES)) i_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .SERVICE_DONE(SERVICE_DONE),
    .CPU_VEC_REQ(CPU_VEC_REQ), .CPU_VEC_ADDR(CPU_VEC_ADDR), .CPU_LEVEL(CPU_LEVEL),
    .BUS_STEAL(BUS_STEAL));
`default_nettype wire

// >>> sim/pie_chk.sv
// port assertions for the interrupt and transfer block
`default_nettype none
module pie_chk #(
    parameter int NODES = 16
) (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SERVICE_DONE,
    input wire logic        CPU_VEC_REQ,
    input wire logic [15:0] CPU_VEC_ADDR,
    input wire logic [3:0]  CPU_LEVEL,
    input wire logic        BUS_STEAL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic [7:0] low_cnt;
    // idle cycles of the vector request, one count for every edge at which it is sampled low
    always_ff @(posedge CLK) begin
        if (!RST_B || CPU_VEC_REQ) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    AST_VEC_MIN_GAP: assert property ($rose(CPU_VEC_REQ) |-> low_cnt >= 6)
        else $error("vector request came too soon");
    AST_DONE_ENDS: assert property (CPU_VEC_REQ && SERVICE_DONE |=>
        !CPU_VEC_REQ || CPU_LEVEL > $past(CPU_LEVEL))
        else $error("vector request outlived service done");
    AST_VEC_HOLD: assert property (CPU_VEC_REQ && !SERVICE_DONE |=> CPU_VEC_REQ &&
        ($stable(CPU_VEC_ADDR) && $stable(CPU_LEVEL) || CPU_LEVEL > $past(CPU_LEVEL)))
        else $error("running service was displaced");
    AST_VEC_SLOT: assert property (CPU_VEC_REQ |->
        CPU_VEC_ADDR[1:0] == 2'h0 && CPU_VEC_ADDR < NODES * 4)
        else $error("vector outside the node table");
    AST_STEAL_PULSE: assert property (BUS_STEAL |=> !BUS_STEAL)
        else $error("transfer took more than one cycle");
    AST_STEAL_NO_SUSPEND: assert property (BUS_STEAL && !$past(SERVICE_DONE) |->
        $stable(CPU_VEC_REQ))
        else $error("transfer disturbed the vector request");
    AST_APB_ANSWER: assert property (PSEL && !PENABLE |=> PREADY) // APB
        else $error("no ready after setup");
    AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && !PENABLE) ##1 !PREADY)
        else $error("ready without setup or too long");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule
`default_nettype wire

// >>> sim/pie_cpu_model.sv
// cpu and bus model: ends vectored services and logs transfers
`default_nettype none
module pie_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        vec_req,
    input  wire logic [15:0] vec_addr,
    input  wire logic        steal,
    input  wire logic [15:0] src,
    input  wire logic [15:0] dst,
    input  wire logic        word,
    input  wire logic [7:0]  delay,
    output logic             service_done
);
    logic [15:0] vec_q[$];
    logic [39:0] steal_q[$];
    logic [7:0]  wait_cnt;
    // answer a presented vector after delay cycles, log every stolen cycle
    always_ff @(posedge clk) begin
        service_done <= 1'b0;
        if (!rst_b) begin
            wait_cnt <= 8'h00;
        end else if (vec_req && !service_done) begin
            if (wait_cnt >= delay) begin
                service_done <= 1'b1;
                wait_cnt <= 8'h00;
                vec_q.push_back(vec_addr);
            end else begin
                wait_cnt <= wait_cnt + 8'h01;
            end
        end
        if (rst_b && steal) begin
            steal_q.push_back({7'h0, word, dst, src});
        end
    end
endmodule
`default_nettype wire

// >>> verilog/pie_top.sv
// prioritized interrupt controller with eight event transfer channels and apb registers
//
// Contract
// - a taken interrupt reaches the cpu vector after at least 7 clocks with jump cache, 11 without.
// - each node is chosen by software to be served as a vectored interrupt or by a transfer channel.
// - a vectored service suspends the program and branches to the node's own vector entry.
// - a channel service takes exactly one cycle from the cpu and does not suspend the program.
// - a channel service moves one byte or word and then steps source, destination or both pointers.
// - the channel counter counts down on each service except in continuous mode.
// - a channel counter reaching zero raises a vectored interrupt at that node's vector.
// - there are eight independent transfer channels.
// - each node has its own control word with request flag, enable flag and priority field.
// - the priority field picks one of sixteen levels for arbitration.
// - a running service is preempted only by a strictly higher priority request.
// - every node has its own dedicated vector location.
// - each fast external input detects rising, falling or both edges as software selects.
// - a software trap with a number takes the interrupt of that number.
// - software setting a node request bit raises a request exactly like hardware would.
//
// The implementer's own choices: the APB register port and the register addresses.
`default_nettype none
module pie_top #(
    parameter int NODES    = pie_pkg::NODES,
    parameter int CHANNELS = pie_pkg::CHANNELS,
    parameter int FAST_IN  = 4
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_B,
    input  wire logic [11:0]          PADDR,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic [NODES-1:0]     PERIPH_REQ,
    input  wire logic [FAST_IN-1:0]   FAST_PIN,
    input  wire logic                 TRAP_VALID,
    input  wire logic [3:0]           TRAP_NUM,
    input  wire logic                 SERVICE_DONE,
    output logic                      CPU_VEC_REQ,
    output logic      [15:0]          CPU_VEC_ADDR,
    output logic      [3:0]           CPU_LEVEL,
    output logic                      BUS_STEAL,
    output logic      [15:0]          BUS_SRC,
    output logic      [15:0]          BUS_DST,
    output logic                      BUS_WORD,
    output logic                      IRQ
);
    localparam int RESP_W = 4;

    pie_pkg::pie_node_s node_reg [NODES];
    pie_pkg::pie_chan_s chan_reg [CHANNELS];
    logic [2*FAST_IN-1:0] edge_sel_reg;
    logic [FAST_IN-1:0]   fast_s1_reg, fast_s2_reg, fast_d_reg;
    logic [FAST_IN-1:0]   fast_hit;
    logic                 cache_en_reg;
    logic [3:0]           ev_st_reg, ev_msk_reg, ev_set;
    logic                 busy_reg;
    logic [3:0]           cur_lvl_reg;
    logic [RESP_W-1:0]    resp_cnt_reg;
    logic                 pend_reg;
    logic [3:0]           pend_node_reg;
    logic                 win_valid;
    logic [3:0]           win_node, win_prio;
    logic                 take, take_etc;
    logic                 vec_take;
    logic [2:0]           take_ch;
    logic                 zero_hit;
    logic                 apb_wr, apb_rd;
    logic [31:0]          rdata_next;

    // decoder for node control word writes
    function automatic logic node_hit(input logic [11:0] a, input int n);
        return a == pie_pkg::OFS_NODE + 12'(4 * n);
    endfunction

    // decoder for channel register writes, sub selects pointer/counter word
    function automatic logic chan_hit(input logic [11:0] a, input int c, input int sub);
        return a == pie_pkg::OFS_CHAN + 12'(16 * c + 4 * sub);
    endfunction

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && PENABLE && !PWRITE;

    // fast input synchronisers and previous value
    // edges come from stage two only
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            fast_s1_reg <= '0;
            fast_s2_reg <= '0;
            fast_d_reg  <= '0;
        end else begin
            fast_s1_reg <= FAST_PIN;
            fast_s2_reg <= fast_s1_reg;
            fast_d_reg  <= fast_s2_reg;
        end
    end

    // per-input edge selection
    generate
        for (genvar i = 0; i < FAST_IN; i++) begin : g_edge
            logic rise, fall;
            pie_pkg::pie_edge_e sel;
            assign sel  = pie_pkg::pie_edge_e'(edge_sel_reg[2*i +: 2]);
            assign rise = fast_s2_reg[i] && !fast_d_reg[i];
            assign fall = !fast_s2_reg[i] && fast_d_reg[i];
            assign fast_hit[i] = (sel == pie_pkg::EDGE_RISE && rise)
                              || (sel == pie_pkg::EDGE_FALL && fall)
                              || (sel == pie_pkg::EDGE_BOTH && (rise || fall));
        end
    endgenerate

    // arbitration: highest enabled level wins, lowest node on a tie
    // ties stay at the lower node
    always_comb begin
        win_valid = 1'b0;
        win_node  = '0;
        win_prio  = '0;
        for (int n = NODES - 1; n >= 0; n--) begin
            if (node_reg[n].req && node_reg[n].en
                    && (!win_valid || node_reg[n].prio >= win_prio)) begin
                win_valid = 1'b1;
                win_node  = 4'(n);
                win_prio  = node_reg[n].prio;
            end
        end
    end

    // accept when idle or strictly above the running level
    assign take = win_valid && !pend_reg && !BUS_STEAL
               && (!busy_reg || win_prio > cur_lvl_reg);
    assign take_etc = node_reg[win_node].etc;
    assign take_ch  = node_reg[win_node].chan;
    assign zero_hit = take && take_etc && !chan_reg[take_ch].cont
                   && chan_reg[take_ch].count == 16'h0001;
    // run-out channel: vector on next accept
    assign vec_take = take && !take_etc;

    // node control words: hardware, trap and software requests
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int n = 0; n < NODES; n++) begin
                node_reg[n] <= '0;
            end
        end else begin
            for (int n = 0; n < NODES; n++) begin
                // clear first, so any set wins
                if (take && win_node == 4'(n) && !zero_hit) begin
                    node_reg[n].req <= 1'b0;
                end
                if (apb_wr && node_hit(PADDR, n)) begin
                    node_reg[n].req  <= PWDATA[pie_pkg::F_REQ];
                    node_reg[n].en   <= PWDATA[pie_pkg::F_EN];
                    node_reg[n].etc  <= PWDATA[pie_pkg::F_ETC];
                    node_reg[n].chan <= PWDATA[pie_pkg::F_CHL +: 3];
                    node_reg[n].prio <= PWDATA[pie_pkg::F_PRIO +: pie_pkg::PRIO_W];
                end
                // request stays, vector follows
                if (zero_hit && win_node == 4'(n)) begin
                    node_reg[n].etc <= 1'b0;
                end
                // set wins over any clear in the same cycle
                if (PERIPH_REQ[n] || (n < FAST_IN && fast_hit[n % FAST_IN])
                        || (TRAP_VALID && TRAP_NUM == 4'(n))) begin
                    node_reg[n].req <= 1'b1;
                end
            end
        end
    end

    // channel pointers and counters
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int c = 0; c < CHANNELS; c++) begin
                chan_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (apb_wr && chan_hit(PADDR, c, 0)) begin
                    chan_reg[c].src <= PWDATA[15:0];
                    chan_reg[c].dst <= PWDATA[31:16];
                end
                if (apb_wr && chan_hit(PADDR, c, 1)) begin
                    chan_reg[c].count   <= PWDATA[15:0];
                    chan_reg[c].inc_src <= PWDATA[pie_pkg::C_INC_SRC];
                    chan_reg[c].inc_dst <= PWDATA[pie_pkg::C_INC_DST];
                    chan_reg[c].word    <= PWDATA[pie_pkg::C_WORD];
                    chan_reg[c].cont    <= PWDATA[pie_pkg::C_CONT];
                end
                // step after the steal captured them
                if (take && take_etc && take_ch == 3'(c)) begin
                    if (chan_reg[c].inc_src) begin
                        chan_reg[c].src <= chan_reg[c].src + (chan_reg[c].word ? 16'h0002 : 16'h0001);
                    end
                    if (chan_reg[c].inc_dst) begin
                        chan_reg[c].dst <= chan_reg[c].dst + (chan_reg[c].word ? 16'h0002 : 16'h0001);
                    end
                    if (!chan_reg[c].cont) begin
                        chan_reg[c].count <= chan_reg[c].count - 16'h0001;
                    end
                end
            end
        end
    end

    // one-cycle bus steal for a channel transfer
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            BUS_STEAL <= 1'b0;
            BUS_SRC   <= '0;
            BUS_DST   <= '0;
            BUS_WORD  <= 1'b0;
        end else begin
            BUS_STEAL <= take && take_etc;
            if (take && take_etc) begin
                BUS_SRC  <= chan_reg[take_ch].src;
                BUS_DST  <= chan_reg[take_ch].dst;
                BUS_WORD <= chan_reg[take_ch].word;
            end
        end
    end

    // vectored service: response delay, then hold vector until cpu finishes
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pend_reg      <= 1'b0;
            pend_node_reg <= '0;
            resp_cnt_reg  <= '0;
            CPU_VEC_REQ   <= 1'b0;
            CPU_VEC_ADDR  <= '0;
            CPU_LEVEL     <= '0;
            busy_reg      <= 1'b0;
            cur_lvl_reg   <= '0;
        end else begin
            if (vec_take) begin
                pend_reg      <= 1'b1;
                pend_node_reg <= win_node;
                cur_lvl_reg   <= win_prio;
                busy_reg      <= 1'b1;
                // vector n+1 edges after accept
                resp_cnt_reg  <= RESP_W'(cache_en_reg ? pie_pkg::RESP_CACHED - 1
                                                      : pie_pkg::RESP_PLAIN - 1);
            end else if (pend_reg && resp_cnt_reg != '0) begin
                resp_cnt_reg <= resp_cnt_reg - RESP_W'(1);
            end else if (pend_reg) begin
                pend_reg     <= 1'b0;
                CPU_VEC_REQ  <= 1'b1;
                CPU_VEC_ADDR <= 16'(pend_node_reg) * pie_pkg::VEC_STEP;
                CPU_LEVEL    <= cur_lvl_reg;
            end
            // keep a vector shown now
            if (SERVICE_DONE && CPU_VEC_REQ && !(pend_reg && resp_cnt_reg == '0)) begin
                CPU_VEC_REQ <= 1'b0;
            end
            // levels are not stacked
            if (SERVICE_DONE && CPU_VEC_REQ && !pend_reg && !vec_take) begin
                busy_reg    <= 1'b0;
                cur_lvl_reg <= '0;
            end
        end
    end

    // sticky event status, write one to clear, set wins
    assign ev_set[pie_pkg::EV_VEC]  = take && !take_etc;
    assign ev_set[pie_pkg::EV_XFER] = take && take_etc;
    assign ev_set[pie_pkg::EV_ZERO] = zero_hit;
    assign ev_set[pie_pkg::EV_TRAP] = TRAP_VALID;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ev_st_reg    <= '0;
            ev_msk_reg   <= '0;
            edge_sel_reg <= '0;
            cache_en_reg <= 1'b0;
            IRQ          <= 1'b0;
        end else begin
            if (apb_wr && PADDR == pie_pkg::OFS_IRQ_MSK) begin
                ev_msk_reg <= PWDATA[3:0];
            end
            if (apb_wr && PADDR == pie_pkg::OFS_EDGE) begin
                edge_sel_reg <= PWDATA[2*FAST_IN-1:0];
            end
            if (apb_wr && PADDR == pie_pkg::OFS_CFG) begin
                cache_en_reg <= PWDATA[0];
            end
            ev_st_reg <= (ev_st_reg & ~((apb_wr && PADDR == pie_pkg::OFS_IRQ_ST)
                                        ? PWDATA[3:0] : 4'h0)) | ev_set;
            // a cycle behind status
            IRQ <= |(ev_st_reg & ev_msk_reg);
        end
    end

    // read mux
    // unmapped words read as zero
    always_comb begin
        rdata_next = pie_pkg::RESET_WORD;
        for (int n = 0; n < NODES; n++) begin
            if (node_hit(PADDR, n)) begin
                rdata_next = {21'h0, node_reg[n].chan, node_reg[n].req, node_reg[n].en,
                              node_reg[n].etc, 1'b0, node_reg[n].prio};
            end
        end
        for (int c = 0; c < CHANNELS; c++) begin
            if (chan_hit(PADDR, c, 0)) begin
                rdata_next = {chan_reg[c].dst, chan_reg[c].src};
            end
            if (chan_hit(PADDR, c, 1)) begin
                rdata_next = {12'h0, chan_reg[c].cont, chan_reg[c].word, chan_reg[c].inc_dst,
                              chan_reg[c].inc_src, chan_reg[c].count};
            end
        end
        unique case (PADDR)
            pie_pkg::OFS_EDGE:    rdata_next = 32'(edge_sel_reg);
            pie_pkg::OFS_STAT:    rdata_next = {22'h0, busy_reg, pend_reg, cur_lvl_reg, win_node};
            pie_pkg::OFS_IRQ_ST:  rdata_next = {28'h0, ev_st_reg};
            pie_pkg::OFS_IRQ_MSK: rdata_next = {28'h0, ev_msk_reg};
            pie_pkg::OFS_CFG:     rdata_next = {31'h0, cache_en_reg};
            default:              rdata_next = rdata_next;
        endcase
    end

    // apb slave: no wait states, error on unaligned address or outside the register blocks
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            // odd, past-end and holes refused
            PSLVERR <= PSEL && !PENABLE && (PADDR[1:0] != 2'h0
                       || PADDR > pie_pkg::OFS_CFG
                       || (PADDR >= pie_pkg::OFS_CHAN + 12'(16 * CHANNELS)
                           && PADDR < pie_pkg::OFS_EDGE)
                       || (PADDR >= 12'(4 * NODES) && PADDR < pie_pkg::OFS_CHAN));
            PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata_next : '0;
        end
    end
endmodule
`default_nettype wire
